// file: logic/tcss_defs.vh
`ifndef TCSS_DEFS_VH
`define TCSS_DEFS_VH

// Register byte addresses
`define TCSS_ADDR_OVF0 20'hF01A0
`define TCSS_ADDR_OVF1 20'hF01A2
`define TCSS_ADDR_OVF2 20'hF01A4
`define TCSS_ADDR_OVF3 20'hF01A6
`define TCSS_ADDR_RUN 20'hF01B0
`define TCSS_ADDR_RUN_UPPER 20'hF01B1
`define TCSS_ADDR_START 20'hF01B2
`define TCSS_ADDR_START_UPPER 20'hF01B3
`define TCSS_ADDR_STOP 20'hF01B4
`define TCSS_ADDR_STOP_UPPER 20'hF01B5

// Register select codes
`define TCSS_SEL_NONE 4'h0
`define TCSS_SEL_OVF0 4'h1
`define TCSS_SEL_OVF1 4'h2
`define TCSS_SEL_OVF2 4'h3
`define TCSS_SEL_OVF3 4'h4
`define TCSS_SEL_RUN 4'h5
`define TCSS_SEL_RUN_UPPER 4'h6
`define TCSS_SEL_START 4'h7
`define TCSS_SEL_START_UPPER 4'h8
`define TCSS_SEL_STOP 4'h9
`define TCSS_SEL_STOP_UPPER 4'hA

// Field layout and reset values
`define TCSS_CHAN_MASK 4'hF
`define TCSS_UPPER_MASK 4'hA
`define TCSS_OVF_BIT 0
`define TCSS_REG_RESET 8'h00

// Operating mode field, bits 3..1 of the channel mode
`define TCSS_MODE_CAPTURE 3'h2
`define TCSS_MODE_CAPTURE_ONE 3'h6
`define TCSS_MODE_ONE_COUNT 3'h4

`endif

// file: logic/tcss_ovf.v
`timescale 1ns/1ps
`include "tcss_defs.vh"

module tcss_ovf (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Channel state
  input wire [2:0] operating_mode_field,
  input wire cnt_overflow,
  input wire capture_event,
  // Flag
  output reg capture_overflow_flag
);

  reg ovf_seen;
  wire capture_mode;

  assign capture_mode = (operating_mode_field == `TCSS_MODE_CAPTURE) ||
                        (operating_mode_field == `TCSS_MODE_CAPTURE_ONE);

  // Overflow remembered until the next capture
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ovf_seen <= 1'b0;
    end else if (capture_event) begin
      ovf_seen <= 1'b0;
    end else if (cnt_overflow) begin
      ovf_seen <= 1'b1;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      capture_overflow_flag <= 1'b0;
    end else if (!capture_mode) begin
      capture_overflow_flag <= 1'b0;
    end else if (capture_event) begin
      // Wrap in the capture cycle itself still counts
      capture_overflow_flag <= ovf_seen | cnt_overflow;
    end
  end

endmodule

// file: logic/tcss_top.v
// What this block does
// - The capture overflow flag can only be set while the mode field is capture or capture-with-one-count.
// - At each capture the flag is set if the counter overflowed since the previous capture.
// - A set flag is cleared at the next capture that saw no overflow.
// - The flag does not change when the counter wraps, only at the following capture.
// - Each overflow status register is read-only, bit 0 is the flag, other bits read zero, reset is 00H.
// - Writing 1 to a start bit sets that channel's run status bit.
// - Writing 1 to a stop bit clears that channel's run status bit.
// - A start also initializes the channel counter and enables counting.
// - Start bits clear themselves as soon as the channel becomes enabled.
// - Both start registers always read as zero.
// - In 8-bit mode the lower start and status bits of channels 1 and 3 drive the lower half.
// - The upper start register has only bits 1 and 3, which start the upper half in 8-bit mode.
// - Run status registers are read-only, unused bits read zero, reset is 00H.
// - A start while counting reinitializes and restarts without an interrupt request; one-count modes with low mode bit clear ignore it.
// - Stop bits clear themselves as soon as the channel is stopped.
`timescale 1ns/1ps
`include "tcss_defs.vh"

module tcss_top (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // CPU byte and bit access
  input wire [19:0] cpu_addr,
  input wire cpu_wr,
  input wire cpu_rd,
  input wire [7:0] cpu_wdata,
  input wire [7:0] cpu_wmask,
  output reg [7:0] cpu_rdata,
  // Channel mode fields, bits 3..0 of each channel mode
  input wire [3:0] mode_ch0,
  input wire [3:0] mode_ch1,
  input wire [3:0] mode_ch2,
  input wire [3:0] mode_ch3,
  input wire [3:0] split_mode,
  // Counter events
  input wire [3:0] cnt_overflow,
  input wire [3:0] capture_event,
  // Run control to counters
  output reg [3:0] channel_run_bit,
  output reg [3:0] upper_half_run_bit,
  output reg [3:0] counter_init,
  output reg [3:0] upper_counter_init,
  output reg [3:0] channel_interrupt_request,
  output reg [3:0] capture_overflow_flag
);

  // Address decode, used for reads and writes
  function [3:0] reg_sel;
    input [19:0] addr;
    begin
      case (addr)
        `TCSS_ADDR_OVF0: reg_sel = `TCSS_SEL_OVF0;
        `TCSS_ADDR_OVF1: reg_sel = `TCSS_SEL_OVF1;
        `TCSS_ADDR_OVF2: reg_sel = `TCSS_SEL_OVF2;
        `TCSS_ADDR_OVF3: reg_sel = `TCSS_SEL_OVF3;
        `TCSS_ADDR_RUN: reg_sel = `TCSS_SEL_RUN;
        `TCSS_ADDR_RUN_UPPER: reg_sel = `TCSS_SEL_RUN_UPPER;
        `TCSS_ADDR_START: reg_sel = `TCSS_SEL_START;
        `TCSS_ADDR_START_UPPER: reg_sel = `TCSS_SEL_START_UPPER;
        `TCSS_ADDR_STOP: reg_sel = `TCSS_SEL_STOP;
        `TCSS_ADDR_STOP_UPPER: reg_sel = `TCSS_SEL_STOP_UPPER;
        default: reg_sel = `TCSS_SEL_NONE;
      endcase
    end
  endfunction

  wire [3:0] wr_sel;
  wire [3:0] rd_sel;
  wire [7:0] wbits;
  wire [11:0] mode_flat;
  wire [3:0] ovf_flag;
  wire [3:0] upper_ok;
  reg [3:0] start_write;
  reg [3:0] start_upper_write;
  reg [3:0] stop_write;
  reg [3:0] stop_upper_write;
  reg [3:0] channel_start_bit;
  reg [3:0] upper_half_start_bit;
  reg [3:0] channel_stop_bit;
  reg [3:0] upper_half_stop_bit;
  reg [3:0] start_blocked;
  reg [3:0] next_run;
  reg [3:0] next_upper_run;
  reg [3:0] next_irq;
  reg [7:0] next_rdata;
  integer i;

  assign wr_sel = cpu_wr ? reg_sel(cpu_addr) : `TCSS_SEL_NONE;
  assign rd_sel = cpu_rd ? reg_sel(cpu_addr) : `TCSS_SEL_NONE;
  // Bit access writes only the masked bits; byte access sets all mask bits
  assign wbits = cpu_wdata & cpu_wmask;
  assign mode_flat = {mode_ch3[3:1], mode_ch2[3:1], mode_ch1[3:1], mode_ch0[3:1]};
  // upper half only for split channels 1 and 3
  assign upper_ok = split_mode & `TCSS_UPPER_MASK;

  // Trigger write decode; unimplemented bits are simply not wired
  always @* begin
    start_write = 4'h0;
    start_upper_write = 4'h0;
    stop_write = 4'h0;
    stop_upper_write = 4'h0;
    case (wr_sel)
      `TCSS_SEL_START: start_write = wbits[3:0] & `TCSS_CHAN_MASK;
      `TCSS_SEL_START_UPPER: start_upper_write = wbits[3:0] & upper_ok;
      `TCSS_SEL_STOP: stop_write = wbits[3:0] & `TCSS_CHAN_MASK;
      `TCSS_SEL_STOP_UPPER: stop_upper_write = wbits[3:0] & upper_ok;
      default: start_write = 4'h0;
    endcase
  end

  // Trigger bits live one cycle, then the run bit has moved
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      channel_start_bit <= 4'h0;
      upper_half_start_bit <= 4'h0;
      channel_stop_bit <= 4'h0;
      upper_half_stop_bit <= 4'h0;
    end else begin
      channel_start_bit <= start_write;
      upper_half_start_bit <= start_upper_write;
      channel_stop_bit <= stop_write;
      upper_half_stop_bit <= stop_upper_write;
    end
  end

  // One-count modes with low mode bit clear ignore starts while counting
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      start_blocked[i] = channel_run_bit[i] && !mode_flat[i*3] &&
                         (((mode_flat[i*3 +: 3] == `TCSS_MODE_ONE_COUNT) &&
                           (i == 0 ? !mode_ch0[0] : i == 1 ? !mode_ch1[0] :
                            i == 2 ? !mode_ch2[0] : !mode_ch3[0])) ||
                          ((mode_flat[i*3 +: 3] == `TCSS_MODE_CAPTURE_ONE) &&
                           (i == 0 ? !mode_ch0[0] : i == 1 ? !mode_ch1[0] :
                            i == 2 ? !mode_ch2[0] : !mode_ch3[0])));
    end
  end

  always @* begin
    // start sets, stop clears; stop wins a tie
    next_run = (channel_run_bit | channel_start_bit) & ~channel_stop_bit;
    next_upper_run = ((upper_half_run_bit | upper_half_start_bit) & ~upper_half_stop_bit) &
                     upper_ok;
    // Start interrupt only from stopped, low mode bit set, not one-count
    next_irq = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      if (channel_start_bit[i] && !channel_run_bit[i] &&
          (mode_flat[i*3 +: 3] != `TCSS_MODE_ONE_COUNT)) begin
        case (i)
          0: next_irq[i] = mode_ch0[0];
          1: next_irq[i] = mode_ch1[0];
          2: next_irq[i] = mode_ch2[0];
          default: next_irq[i] = mode_ch3[0];
        endcase
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      channel_run_bit <= 4'h0;
      upper_half_run_bit <= 4'h0;
      counter_init <= 4'h0;
      upper_counter_init <= 4'h0;
      channel_interrupt_request <= 4'h0;
    end else begin
      channel_run_bit <= next_run;
      upper_half_run_bit <= next_upper_run;
      // counter load pulse on each accepted start
      counter_init <= channel_start_bit & ~start_blocked & ~channel_stop_bit;
      upper_counter_init <= upper_half_start_bit & ~upper_half_stop_bit & upper_ok;
      channel_interrupt_request <= next_irq & ~channel_stop_bit;
    end
  end

  // Per channel overflow trackers
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : ovf_ch
      tcss_ovf u_ovf (
        .clk(clk),
        .nrst(nrst),
        .operating_mode_field(mode_flat[g*3 +: 3]),
        .cnt_overflow(cnt_overflow[g]),
        .capture_event(capture_event[g]),
        .capture_overflow_flag(ovf_flag[g])
      );
    end
  endgenerate

  // Registered read data, zero for write-only and unmapped
  always @* begin
    next_rdata = `TCSS_REG_RESET;
    case (rd_sel)
      `TCSS_SEL_OVF0: next_rdata[`TCSS_OVF_BIT] = ovf_flag[0];
      `TCSS_SEL_OVF1: next_rdata[`TCSS_OVF_BIT] = ovf_flag[1];
      `TCSS_SEL_OVF2: next_rdata[`TCSS_OVF_BIT] = ovf_flag[2];
      `TCSS_SEL_OVF3: next_rdata[`TCSS_OVF_BIT] = ovf_flag[3];
      `TCSS_SEL_RUN: next_rdata[3:0] = channel_run_bit;
      `TCSS_SEL_RUN_UPPER: next_rdata[3:0] = upper_half_run_bit;
      `TCSS_SEL_START: next_rdata = `TCSS_REG_RESET;
      default: next_rdata = `TCSS_REG_RESET;
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cpu_rdata <= `TCSS_REG_RESET;
      capture_overflow_flag <= 4'h0;
    end else begin
      cpu_rdata <= next_rdata;
      capture_overflow_flag <= ovf_flag;
    end
  end

endmodule

// file: verification/tcss_monitor.sv
`timescale 1ns/1ps
`include "tcss_defs.vh"
module tcss_monitor (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // CPU access
  input wire [19:0] cpu_addr,
  input wire cpu_wr,
  input wire cpu_rd,
  input wire [7:0] cpu_wdata,
  input wire [7:0] cpu_rdata,
  // Channel setup and events
  input wire [3:0] mode_ch0,
  input wire [3:0] split_mode,
  input wire [3:0] cnt_overflow,
  input wire [3:0] capture_event,
  // Run control and flags
  input wire [3:0] channel_run_bit,
  input wire [3:0] upper_half_run_bit,
  input wire [3:0] counter_init,
  input wire [3:0] channel_interrupt_request,
  input wire [3:0] capture_overflow_flag
);
  wire cap0 = mode_ch0[3:1] == `TCSS_MODE_CAPTURE || mode_ch0[3:1] == `TCSS_MODE_CAPTURE_ONE;
  wire stp0 = cpu_wr && cpu_addr == `TCSS_ADDR_STOP && cpu_wdata[0];
  reg seen;
  // Pending wrap; any capture consumes it, whatever the mode
  always @(posedge clk or negedge nrst)
    if (!nrst)
      seen <= 1'b0;
    else if (capture_event[0])
      seen <= 1'b0;
    else if (cnt_overflow[0])
      seen <= 1'b1;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_wr(a, b);
    cpu_wr && cpu_addr == a && cpu_wdata[b];
  endsequence
  a_ovf_mode_only: assert property (capture_overflow_flag[0] |-> $past(cap0, 2))
    else $error("overflow flag set outside capture mode");
  a_ovf_set_cap: assert property (
    capture_event[0] && cap0 && (cnt_overflow[0] || seen) |-> ##2 capture_overflow_flag[0])
    else $error("overflow flag not set at capture");
  a_ovf_clr_cap: assert property (
    capture_event[0] && cap0 && !cnt_overflow[0] && !seen |-> ##2 !capture_overflow_flag[0])
    else $error("overflow flag not cleared at capture");
  a_ovf_wrap_hold: assert property (
    cnt_overflow[0] && !capture_event[0] && cap0 |-> ##2 $stable(capture_overflow_flag[0]))
    else $error("overflow flag moved on a wrap");
  a_ovf_read_bit: assert property (
    cpu_rd && cpu_addr == `TCSS_ADDR_OVF0 |=> cpu_rdata == {7'h00, capture_overflow_flag[0]})
    else $error("overflow status read wrong");
  a_run_on_start: assert property (
    s_wr(`TCSS_ADDR_START, 0) ##0 !stp0 |-> ##2 channel_run_bit[0])
    else $error("start did not set run bit");
  a_run_off_stop: assert property (stp0 |-> ##2 !channel_run_bit[0])
    else $error("stop did not clear run bit");
  a_init_on_run: assert property ($rose(channel_run_bit[0]) |-> counter_init[0])
    else $error("run began without counter init");
  a_trig_read_zero: assert property (
    cpu_rd && (cpu_addr == `TCSS_ADDR_START || cpu_addr == `TCSS_ADDR_START_UPPER)
    |=> cpu_rdata == 8'h00)
    else $error("start register read not zero");
  a_upper_run_set: assert property (
    s_wr(`TCSS_ADDR_START_UPPER, 1) ##0 split_mode[1] |-> ##2 upper_half_run_bit[1])
    else $error("upper start did not set upper run bit");
  a_restart_no_irq: assert property (
    channel_run_bit[0] ##0 s_wr(`TCSS_ADDR_START, 0) |-> ##2 !channel_interrupt_request[0])
    else $error("restart raised interrupt");
endmodule

bind tcss_top tcss_monitor i_tcss_monitor (.clk(clk), .nrst(nrst), .cpu_addr(cpu_addr),
  .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
  .mode_ch0(mode_ch0), .split_mode(split_mode), .cnt_overflow(cnt_overflow),
  .capture_event(capture_event), .channel_run_bit(channel_run_bit),
  .upper_half_run_bit(upper_half_run_bit), .counter_init(counter_init),
  .channel_interrupt_request(channel_interrupt_request),
  .capture_overflow_flag(capture_overflow_flag));

// file: verification/tcss_tb_top.sv
`timescale 1ns/1ps
`include "tcss_defs.vh"
module tcss_tb_top;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg [19:0] cpu_addr = 20'h00000;
  reg cpu_wr = 1'b0;
  reg cpu_rd = 1'b0;
  reg [7:0] cpu_wdata = 8'h00;
  reg [3:0] m0 = 4'h0, m1 = 4'h0, m2 = 4'h0, m3 = 4'h0, split = 4'h0, ovf = 4'h0, cap = 4'h0;
  wire [7:0] rdata;
  wire [3:0] run, uprun, init, uinit, irq, flag;
  integer fails = 0;
  integer n_compared = 0;
  integer cyc = 0;
  tcss_top i_tcss_top (.clk(clk), .nrst(nrst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_wmask(8'hFF), .cpu_rdata(rdata),
    .mode_ch0(m0), .mode_ch1(m1), .mode_ch2(m2), .mode_ch3(m3), .split_mode(split),
    .cnt_overflow(ovf), .capture_event(cap), .channel_run_bit(run),
    .upper_half_run_bit(uprun), .counter_init(init), .upper_counter_init(uinit),
    .channel_interrupt_request(irq), .capture_overflow_flag(flag));
  always #50 clk = ~clk;
  task close_out;
    begin
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails = fails + 1;
      close_out;
    end
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Returns after the edge where run status lands
  task wr(input [19:0] a, input [7:0] d);
    begin
      @(posedge clk);
      cpu_addr <= a;
      cpu_wdata <= d;
      cpu_wr <= 1'b1;
      @(posedge clk);
      cpu_wr <= 1'b0;
      // Run bit and one-cycle init pulse both stand after this edge
      @(posedge clk);
      #1;
    end
  endtask
  task rd(input [19:0] a, input [7:0] exp);
    begin
      @(posedge clk);
      cpu_addr <= a;
      cpu_rd <= 1'b1;
      @(posedge clk);
      cpu_rd <= 1'b0;
      #1;
      chk(rdata, exp);
    end
  endtask
  task ev(input [3:0] o, input [3:0] c, input [3:0] exp);
    begin
      @(posedge clk);
      ovf <= o;
      cap <= c;
      @(posedge clk);
      ovf <= 4'h0;
      cap <= 4'h0;
      @(posedge clk);
      #1;
      chk({4'h0, flag}, {4'h0, exp});
    end
  endtask
  task t_reset;
    integer i;
    begin
      wr(`TCSS_ADDR_RUN, 8'h0F);
      wr(`TCSS_ADDR_OVF0, 8'hFF);
      for (i = 0; i < 8; i = i + 1)
        rd(i < 4 ? 20'(`TCSS_ADDR_OVF0 + 2 * i) : 20'(`TCSS_ADDR_RUN + i - 4), 8'h00);
      rd(20'hF01A1, 8'h00);
      $display("reset values done");
    end
  endtask
  task t_start_stop;
    begin
      wr(`TCSS_ADDR_START, 8'h0F);
      chk({4'h0, run}, 8'h0F);
      chk({4'h0, init}, 8'h0F);
      rd(`TCSS_ADDR_START, 8'h00);
      rd(`TCSS_ADDR_RUN, 8'h0F);
      wr(`TCSS_ADDR_STOP, 8'h05);
      chk({4'h0, run}, 8'h0A);
      rd(`TCSS_ADDR_STOP, 8'h00);
      wr(`TCSS_ADDR_STOP, 8'h0A);
      chk({4'h0, run}, 8'h00);
      $display("start stop done");
    end
  endtask
  task t_restart;
    begin
      @(posedge clk);
      m0 <= 4'h1;
      repeat (4) @(posedge clk);
      wr(`TCSS_ADDR_START, 8'h01);
      chk({4'h0, irq}, 8'h01);
      wr(`TCSS_ADDR_START, 8'h01);
      chk({4'h0, init}, 8'h01);
      chk({4'h0, irq}, 8'h00);
      wr(`TCSS_ADDR_STOP, 8'h01);
      $display("restart done");
    end
  endtask
  task t_split;
    begin
      @(posedge clk);
      split <= 4'hA;
      wr(`TCSS_ADDR_START_UPPER, 8'h0A);
      chk({uprun, run}, 8'hA0);
      chk({4'h0, uinit}, 8'h0A);
      wr(`TCSS_ADDR_START, 8'h02);
      chk({uprun, run}, 8'hA2);
      rd(`TCSS_ADDR_START_UPPER, 8'h00);
      wr(`TCSS_ADDR_STOP_UPPER, 8'h0A);
      wr(`TCSS_ADDR_STOP, 8'h02);
      chk({uprun, run}, 8'h00);
      $display("split mode done");
    end
  endtask
  task t_ovf;
    integer i, j;
    reg [2:0] m;
    reg [3:0] e;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        m = i == 0 ? 3'h2 : i == 1 ? 3'h6 : i == 2 ? 3'h0 : i == 3 ? 3'h3 : 3'h4;
        e = i < 2 ? 4'hF : 4'h0;
        @(posedge clk);
        m0 <= {m, 1'b0};
        m1 <= {m, 1'b0};
        m2 <= {m, 1'b0};
        m3 <= {m, 1'b0};
        ev(4'h0, 4'hF, 4'h0);
        ev(4'hF, 4'h0, 4'h0);
        ev(4'h0, 4'hF, e);
        for (j = 0; j < 4; j = j + 1)
          rd(20'(`TCSS_ADDR_OVF0 + 2 * j), {7'h00, e[j]});
        ev(4'hF, 4'h0, e);
        ev(4'h0, 4'hF, e);
        ev(4'h0, 4'hF, 4'h0);
      end
      $display("overflow flag done");
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_start_stop;
    t_restart;
    t_split;
    t_ovf;
    close_out;
  end
endmodule
